/* File: inc/dces_pkg.sv */
// Constants for the DMA channel enable and structure-select register block
// How it works
// RQ1: Enable set register reads channel enable state.
// RQ2: Bit n belongs to channel n.
// RQ3: Enable set write ones enable; zeros ignored.
// RQ4: Enable clear is write-only; ones disable.
// RQ5: Completed DMA cycle clears channel enable.
// RQ6: Alternate set register reads structure in use.
// RQ7: Alternate set write ones select alternate.
// RQ8: Primary select write ones select primary.
// RQ9: Controller sets/clears select during ping-pong, scatter-gather.
// RQ10: Upper bits and clear registers read zero.
// RQ11: Collisions: software wins enable, hardware wins select.
package dces_pkg;
  localparam int          NUM_CHAN         = 16;
  localparam int          ADDR_W           = 32;
  localparam logic [31:0] OFS_EN_SET       = 32'h40010028;
  localparam logic [31:0] OFS_EN_CLR       = 32'h4001002c;
  localparam logic [31:0] OFS_ALT_SET      = 32'h40010030;
  localparam logic [31:0] OFS_PRI_SEL      = 32'h40010034;
  localparam logic [15:0] RST_CHAN_BITS    = 16'h0000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

/* File: logic/dces_chan_bit.sv */
// One channel's enable and structure-select flip-flop pair
`timescale 1ns/10ps
module dces_chan_bit
  import dces_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Software strobes
  input  wire logic en_set,
  input  wire logic en_clr,
  input  wire logic alt_set,
  input  wire logic pri_sel,
  // Controller updates
  input  wire logic done,
  input  wire logic hw_alt_set,
  input  wire logic hw_alt_clr,
  // State
  output logic      enabled,
  output logic      alt_sel
);
  typedef struct packed {
    logic en;
    logic alt;
  } dces_bit_t;

  dces_bit_t st_r;
  dces_bit_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // Software writes are applied after completion so they win
    if (done) begin
      st_nxt.en = 1'b0; // [RQ5]
    end
    if (en_set) begin
      st_nxt.en = 1'b1; // [RQ3] [RQ11]
    end
    if (en_clr) begin
      st_nxt.en = 1'b0; // [RQ4]
    end
    if (alt_set) begin
      st_nxt.alt = 1'b1; // [RQ7]
    end
    if (pri_sel) begin
      st_nxt.alt = 1'b0; // [RQ8]
    end
    // Hardware sequencing wins: the engine is mid-transfer and must not lose step
    if (hw_alt_set) begin
      st_nxt.alt = 1'b1; // [RQ9] [RQ11]
    end
    if (hw_alt_clr) begin
      st_nxt.alt = 1'b0; // [RQ9]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign enabled = st_r.en;
  assign alt_sel = st_r.alt;
endmodule

/* File: logic/dces_top.sv */
// AXI4-Lite register block for per-channel DMA enable and structure select
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module dces_top
  import dces_pkg::*;
#(
  parameter int NCH = NUM_CHAN
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Transfer engine side
  input  wire logic [NCH-1:0]    chan_done,
  input  wire logic [NCH-1:0]    chan_alt_hw_set,
  input  wire logic [NCH-1:0]    chan_alt_hw_clr,
  output logic [NCH-1:0]         chan_enabled,
  output logic [NCH-1:0]         chan_alt_sel
);
  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                aw_held;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
  } dces_bus_t;

  dces_bus_t bus_r;
  dces_bus_t bus_nxt;

  logic [NCH-1:0] en_q;
  logic [NCH-1:0] alt_q;
  logic [NCH-1:0] sw_en_set;
  logic [NCH-1:0] sw_en_clr;
  logic [NCH-1:0] sw_alt_set;
  logic [NCH-1:0] sw_pri_sel;
  logic           wr_go;
  logic [15:0]    wbits;
  logic [NCH-1:0] chan_en_r;
  logic [NCH-1:0] chan_alt_r;

  // Write commits once both address and data are held and no response is pending
  assign wr_go = bus_r.aw_held && bus_r.w_held && !bus_r.bvalid;
  // Only the low two byte lanes carry channel bits
  assign wbits = {bus_r.w_strb[1] ? bus_r.w_data[15:8] : 8'h00,
                  bus_r.w_strb[0] ? bus_r.w_data[7:0]  : 8'h00};

  always_comb begin
    sw_en_set  = '0;
    sw_en_clr  = '0;
    sw_alt_set = '0;
    sw_pri_sel = '0;
    if (wr_go) begin
      case (bus_r.aw_addr)
        OFS_EN_SET:  sw_en_set  = wbits[NCH-1:0]; // [RQ3]
        OFS_EN_CLR:  sw_en_clr  = wbits[NCH-1:0]; // [RQ4]
        OFS_ALT_SET: sw_alt_set = wbits[NCH-1:0]; // [RQ7]
        OFS_PRI_SEL: sw_pri_sel = wbits[NCH-1:0]; // [RQ8]
        default: begin
        end
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      // Bit gi of every register is channel gi
      dces_chan_bit u_bit ( // [RQ2]
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .en_set     (sw_en_set[gi]),
        .en_clr     (sw_en_clr[gi]),
        .alt_set    (sw_alt_set[gi]),
        .pri_sel    (sw_pri_sel[gi]),
        .done       (chan_done[gi]),
        .hw_alt_set (chan_alt_hw_set[gi]),
        .hw_alt_clr (chan_alt_hw_clr[gi]),
        .enabled    (en_q[gi]),
        .alt_sel    (alt_q[gi])
      );
    end
  endgenerate

  always_comb begin
    bus_nxt = bus_r;
    // Write address and data taken independently, in either order
    if (s_axi_awvalid && bus_r.awready) begin
      bus_nxt.aw_held = 1'b1;
      bus_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && bus_r.wready) begin
      bus_nxt.w_held = 1'b1;
      bus_nxt.w_data = s_axi_wdata;
      bus_nxt.w_strb = s_axi_wstrb;
    end
    bus_nxt.awready = !bus_nxt.aw_held && !bus_r.bvalid;
    bus_nxt.wready  = !bus_nxt.w_held && !bus_r.bvalid;
    if (wr_go) begin
      bus_nxt.aw_held = 1'b0;
      bus_nxt.w_held  = 1'b0;
      bus_nxt.bvalid  = 1'b1;
      bus_nxt.awready = 1'b0;
      bus_nxt.wready  = 1'b0;
      case (bus_r.aw_addr)
        OFS_EN_SET, OFS_EN_CLR, OFS_ALT_SET, OFS_PRI_SEL: bus_nxt.bresp = RESP_OKAY;
        default: bus_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (bus_r.bvalid && s_axi_bready) begin
      bus_nxt.bvalid  = 1'b0;
      bus_nxt.awready = 1'b1;
      bus_nxt.wready  = 1'b1;
    end
    // Read: one outstanding, answered the cycle after the address is taken
    if (s_axi_arvalid && bus_r.arready) begin
      bus_nxt.arready = 1'b0;
      bus_nxt.rvalid  = 1'b1;
      bus_nxt.rresp   = RESP_OKAY;
      bus_nxt.rdata   = 32'h00000000; // [RQ10]
      case (s_axi_araddr)
        OFS_EN_SET:  bus_nxt.rdata[NCH-1:0] = en_q; // [RQ1]
        OFS_ALT_SET: bus_nxt.rdata[NCH-1:0] = alt_q; // [RQ6]
        OFS_EN_CLR, OFS_PRI_SEL: bus_nxt.rdata = 32'h00000000; // [RQ10]
        default: bus_nxt.rresp = RESP_SLVERR;
      endcase
    end
    if (bus_r.rvalid && s_axi_rready) begin
      bus_nxt.rvalid  = 1'b0;
      bus_nxt.arready = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_r         <= '0;
      bus_r.awready <= 1'b1;
      bus_r.wready  <= 1'b1;
      bus_r.arready <= 1'b1;
      chan_en_r     <= '0;
      chan_alt_r    <= '0;
    end else begin
      bus_r      <= bus_nxt;
      chan_en_r  <= en_q;
      chan_alt_r <= alt_q;
    end
  end

  assign s_axi_awready = bus_r.awready;
  assign s_axi_wready  = bus_r.wready;
  assign s_axi_bvalid  = bus_r.bvalid;
  assign s_axi_bresp   = bus_r.bresp;
  assign s_axi_arready = bus_r.arready;
  assign s_axi_rvalid  = bus_r.rvalid;
  assign s_axi_rresp   = bus_r.rresp;
  assign s_axi_rdata   = bus_r.rdata;
  // Registered copies cost one cycle of lag versus the live state
  assign chan_enabled  = chan_en_r;
  assign chan_alt_sel  = chan_alt_r;

  // Assertions
  chk_done_clears_en: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ5]
    (chan_done[0] && !sw_en_set[0]) |=> ##1 !chan_enabled[0])
    else $error("channel 0 still enabled after completion");
  chk_set_enables: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ3]
    (sw_en_set[1] && !sw_en_clr[1]) |=> ##1 chan_enabled[1])
    else $error("enable set write did not enable channel");
  chk_clr_disables: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ4]
    sw_en_clr[2] |=> ##1 !chan_enabled[2])
    else $error("enable clear write did not disable channel");
  chk_sw_wins_en: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ11]
    (chan_done[3] && sw_en_set[3] && !sw_en_clr[3]) |=> en_q[3])
    else $error("completion beat software enable");
  chk_hw_wins_alt: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ9]
    (chan_alt_hw_set[4] && !chan_alt_hw_clr[4]) |=> alt_q[4])
    else $error("hardware alternate set lost");
  chk_pri_sel_clr: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ8]
    (sw_pri_sel[5] && !chan_alt_hw_set[5]) |=> ##1 !chan_alt_sel[5])
    else $error("primary select write ignored");
  chk_alt_set_sets: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ7]
    (sw_alt_set[6] && !sw_pri_sel[6] && !chan_alt_hw_clr[6]) |=> alt_q[6])
    else $error("alternate set write ignored");
  chk_rd_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ10]
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_rd_enable: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ1]
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_EN_SET)
      |=> s_axi_rvalid && s_axi_rdata[NCH-1:0] == $past(en_q))
    else $error("enable readback mismatch");
  chk_rd_alt: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ6]
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_ALT_SET)
      |=> s_axi_rvalid && s_axi_rdata[NCH-1:0] == $past(alt_q))
    else $error("structure select readback mismatch");
  chk_rd_clr_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ10]
    (s_axi_arvalid && s_axi_arready
      && (s_axi_araddr == OFS_EN_CLR || s_axi_araddr == OFS_PRI_SEL))
      |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
    else $error("write-only register did not read zero");
  chk_wr_resp_okay: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ3]
    (wr_go && bus_r.aw_addr == OFS_EN_SET) |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("mapped write not answered okay");
  // A held response must not change under a stalled master
  chk_b_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ3]
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_r_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ1]
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_aw_busy: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ3]
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while response pending");

  // Every channel is checked, not only the sample channels above
  genvar ga;
  generate
    for (ga = 0; ga < NCH; ga++) begin : g_chk
      chk_en_done: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ5]
        (chan_done[ga] && !sw_en_set[ga]) |=> !en_q[ga])
        else $error("completion did not clear enable");
      chk_en_sw_set: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ11]
        (sw_en_set[ga] && !sw_en_clr[ga]) |=> en_q[ga])
        else $error("software enable lost");
      chk_en_sw_clr: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ4]
        sw_en_clr[ga] |=> !en_q[ga])
        else $error("software disable lost");
      chk_en_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ3]
        (!chan_done[ga] && !sw_en_set[ga] && !sw_en_clr[ga])
          |=> en_q[ga] == $past(en_q[ga]))
        else $error("enable changed with no cause");
      chk_alt_hw_clr: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ9]
        chan_alt_hw_clr[ga] |=> !alt_q[ga])
        else $error("hardware primary select lost");
      chk_alt_hw_set: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ11]
        (chan_alt_hw_set[ga] && !chan_alt_hw_clr[ga]) |=> alt_q[ga])
        else $error("hardware alternate select lost");
      chk_alt_sw_set: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ7]
        (sw_alt_set[ga] && !chan_alt_hw_clr[ga]) |=> alt_q[ga])
        else $error("software alternate select lost");
      chk_alt_sw_pri: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ8]
        (sw_pri_sel[ga] && !chan_alt_hw_set[ga]) |=> !alt_q[ga])
        else $error("software primary select lost");
      chk_out_en_lag: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ2]
        chan_enabled[ga] == $past(en_q[ga]))
        else $error("enable output not one cycle behind state");
      chk_out_alt_lag: assert property (@(posedge core_clk) disable iff (!rst_n) // [RQ2]
        chan_alt_sel[ga] == $past(alt_q[ga]))
        else $error("select output not one cycle behind state");
    end
  endgenerate
endmodule

/* File: bench/dma_channel_enable_alt_select_bench.sv */
// Register-level bench for the channel enable and structure-select block
`timescale 1ns/10ps
module dma_channel_enable_alt_select_bench;
  import dces_pkg::*;
  logic        clk = 0, rst_n = 0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [15:0] done = '0, hw_set = '0, hw_clr = '0, en_out, alt_out;
  int          err_count = 0, cmp_count = 0;

  always #5 clk = ~clk;

  dces_top dut (.core_clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chan_done(done), .chan_alt_hw_set(hw_set),
    .chan_alt_hw_clr(hw_clr), .chan_enabled(en_out), .chan_alt_sel(alt_out));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data are offered together and released one by one as taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    logic aw_d, w_d;
    aw_d = 0;
    w_d = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_d && w_d)) begin
      @(posedge clk);
      if (!aw_d && awready === 1'b1) begin
        aw_d = 1;
        awvalid <= 0;
      end
      if (!w_d && wready === 1'b1) begin
        w_d = 1;
        wvalid <= 0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 0;
  endtask

  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    chk("rdata", rdata, ed);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 0;
  endtask

  // Outputs trail the register state, so let the pipeline settle first
  task automatic outs(input logic [15:0] ee, ea);
    repeat (3) @(posedge clk);
    chk("chan_enabled", {16'h0, en_out}, {16'h0, ee});
    chk("chan_alt_sel", {16'h0, alt_out}, {16'h0, ea});
  endtask

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #20000;
    err_count++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(OFS_EN_SET, 32'h0, RESP_OKAY);
    rd(OFS_ALT_SET, 32'h0, RESP_OKAY);
    wr(OFS_EN_SET, 32'hffff8001, RESP_OKAY);
    rd(OFS_EN_SET, 32'h00008001, RESP_OKAY);
    outs(16'h8001, 16'h0);
    wr(OFS_EN_SET, 32'h00000002, RESP_OKAY);
    rd(OFS_EN_SET, 32'h00008003, RESP_OKAY);
    wr(OFS_EN_CLR, 32'h00000001, RESP_OKAY);
    rd(OFS_EN_SET, 32'h00008002, RESP_OKAY);
    rd(OFS_EN_CLR, 32'h0, RESP_OKAY);
    done <= 16'h8000;
    @(posedge clk);
    done <= 16'h0;
    outs(16'h0002, 16'h0);
    rd(OFS_EN_SET, 32'h00000002, RESP_OKAY);
    wr(OFS_ALT_SET, 32'hffff00f0, RESP_OKAY);
    rd(OFS_ALT_SET, 32'h000000f0, RESP_OKAY);
    wr(OFS_PRI_SEL, 32'h00000030, RESP_OKAY);
    rd(OFS_ALT_SET, 32'h000000c0, RESP_OKAY);
    rd(OFS_PRI_SEL, 32'h0, RESP_OKAY);
    hw_set <= 16'h0001;
    hw_clr <= 16'h0080;
    @(posedge clk);
    hw_set <= 16'h0;
    hw_clr <= 16'h0;
    outs(16'h0002, 16'h0041);
    hw_clr <= 16'h0100;
    wr(OFS_ALT_SET, 32'h00000100, RESP_OKAY);
    hw_clr <= 16'h0;
    rd(OFS_ALT_SET, 32'h00000041, RESP_OKAY);
    wr(OFS_EN_SET, 32'h0000001d, RESP_OKAY);
    wr(OFS_EN_CLR, 32'h00000004, RESP_OKAY);
    rd(OFS_EN_SET, 32'h0000001b, RESP_OKAY);
    done <= 16'h0001;
    @(posedge clk);
    done <= 16'h0;
    rd(OFS_EN_SET, 32'h0000001a, RESP_OKAY);
    // Completion held across the write: software wins its cycle, later cycles clear
    done <= 16'h0008;
    wr(OFS_EN_SET, 32'h00000008, RESP_OKAY);
    done <= 16'h0;
    rd(OFS_EN_SET, 32'h00000012, RESP_OKAY);
    hw_set <= 16'h0010;
    @(posedge clk);
    hw_set <= 16'h0;
    outs(16'h0012, 16'h0051);
    wr(32'h40010038, 32'h0000ffff, RESP_SLVERR);
    rd(32'h40010038, 32'h0, RESP_SLVERR);
    outs(16'h0012, 16'h0051);
    end_sim();
  end
endmodule
